// ### rtl/programmable_crc_generator.sv
// Programmable CRC generator of up to 32 bits with input FIFO and two-bit-per-cycle engine.
`timescale 1ns/10ps
`include "crc_params.svh"

// Notes on behaviour
// - Polynomial order up to 32, field is length-1.
// - Set term bit enables XOR at that position.
// - x^0 always applied, lowest term reads zero.
// - Top term implicit at length 32.
// - Data width 1 to 32, field is width-1.
// - FIFO depth 4, 8 or 16 by width.
// - Narrow widths take a byte, upper bits ignored.
// - Count increments when width's top byte written.
// - Shift starts only with go set and words waiting.
// - Load word, decrement count, shift two bits.
// - Full flag at depth maximum.
// - Empty flag at zero count.
// - Module off empties FIFO, count zero.
// - MSB first by default, LSB first selectable.
// - Direction changes input order only.
// - Select 0: interrupt when count goes 1 to 0.
// - Select 1: interrupt on hardware go clear only.
// - Go clears itself when calculation completes.
// - Module off resets engine, result, high data.
module programmable_crc_generator (
  input wire logic clk_i,                      // Clock, 100 MHz.
  input wire logic rst_n_i,                    // Asynchronous reset, active low.
  input wire logic ce_i,                       // Clock enable; all state holds while low.
  input wire logic module_on_i,                // Module enable level.
  input wire logic lsb_first_select_i,         // Data shifted in LSB first when high.
  input wire logic irq_condition_select_i,     // Interrupt condition select.
  input wire logic [4:0] poly_length_field_i,  // Polynomial length minus one.
  input wire logic [4:0] data_width_field_i,   // Data width minus one.
  input wire logic [15:0] poly_terms_low_i,    // Term enables x^15..x^1, bit 0 unused.
  input wire logic [15:0] poly_terms_high_i,   // Term enables x^31..x^16.
  output logic [15:0] poly_terms_low_rd_o,     // Low term enables as read back.
  input wire logic shift_go_set_i,             // Software pulse that sets go.
  input wire logic shift_go_clr_i,             // Software pulse that clears go.
  output logic shift_go_o,                     // Go bit.
  input wire logic data_input_low_wr_i,        // Write pulse to the low data half.
  input wire logic data_input_high_wr_i,       // Write pulse to the high data half.
  input wire logic [1:0] data_be_i,            // Byte enables of a data write.
  input wire logic [15:0] data_wdata_i,        // Data write value.
  input wire logic result_low_wr_i,            // Write pulse to the low result half.
  input wire logic result_high_wr_i,           // Write pulse to the high result half.
  input wire logic [15:0] result_wdata_i,      // Result write value.
  output logic [31:0] result_pair_o,           // Running CRC value.
  output logic [4:0] valid_word_count_o,       // Words waiting in the FIFO.
  output logic fifo_full_flag_o,               // FIFO at depth maximum.
  output logic fifo_empty_flag_o,              // FIFO holds no word.
  output logic irq_o                           // Interrupt pulse, one cycle.
);
  crc_fifo_if fif ();

  crc_pkg::state_t state_r, state_nxt;   // Shift engine state.
  crc_pkg::word_t buf_r, buf_nxt;        // Shift buffer.
  logic [`CRC_BITS_W-1:0] bits_r, bits_nxt; // Bits left in the buffer.
  crc_pkg::word_t crc_r, crc_nxt;        // Running CRC.
  logic go_r, go_nxt;                    // Go bit.
  logic irq_r, irq_nxt;                  // Interrupt pulse register.
  crc_pkg::half_t dlow_r, dlow_nxt;      // Low data half.
  crc_pkg::half_t dhigh_r, dhigh_nxt;    // High data half.
  crc_pkg::count_t depth;                // Depth for the current width.
  crc_pkg::word_t width_mask;            // Ones over the data width.
  crc_pkg::word_t len_mask;              // Ones over the polynomial length.
  crc_pkg::word_t poly;                  // Effective feedback taps.
  crc_pkg::word_t crc_step;              // CRC after this cycle's shifts.
  crc_pkg::word_t buf_step;              // Buffer after this cycle's shifts.
  logic [`CRC_BITS_W-1:0] nsteps;        // Bits shifted this cycle.
  logic push_req;                        // A data write completed a word.
  logic push_ok;                         // That word fits in the FIFO.
  logic pop;                             // Engine takes a word this cycle.
  logic hw_done;                         // Engine finished with FIFO empty.

  crc_fifo u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .fif(fif)
  );

  // Depth chosen by width field: wide, middle or narrow words.
  always_comb begin
    if (data_width_field_i >= `CRC_WIDE_MIN) begin
      depth = `CRC_DEPTH_WIDE;
    end else if (data_width_field_i >= `CRC_MID_MIN) begin
      depth = `CRC_DEPTH_MID;
    end else begin
      depth = `CRC_DEPTH_NARROW;
    end
  end

  // Masks and taps; bit 0 is always a tap and the top term is implied.
  assign width_mask = ~(`CRC_TERMS_FLOOR << data_width_field_i);
  assign len_mask = ~(`CRC_TERMS_FLOOR << poly_length_field_i);
  assign poly = {poly_terms_high_i, poly_terms_low_i[15:1], 1'b1} & len_mask;
  assign poly_terms_low_rd_o = {poly_terms_low_i[15:1], 1'b0};

  // Data halves; a write to the byte holding the width's top bit pushes the word.
  always_comb begin
    dlow_nxt = dlow_r;
    dhigh_nxt = dhigh_r;
    push_req = 1'b0;
    if (data_input_low_wr_i) begin
      if (data_be_i[0]) begin
        dlow_nxt[7:0] = data_wdata_i[7:0];
      end
      if (data_be_i[1]) begin
        dlow_nxt[15:8] = data_wdata_i[15:8];
      end
    end
    if (data_input_high_wr_i) begin
      if (data_be_i[0]) begin
        dhigh_nxt[7:0] = data_wdata_i[7:0];
      end
      if (data_be_i[1]) begin
        dhigh_nxt[15:8] = data_wdata_i[15:8];
      end
    end
    unique case (data_width_field_i[4:3])
      2'h0: push_req = data_input_low_wr_i && data_be_i[0];
      2'h1: push_req = data_input_low_wr_i && data_be_i[1];
      2'h2: push_req = data_input_high_wr_i && data_be_i[0];
      2'h3: push_req = data_input_high_wr_i && data_be_i[1];
    endcase
    if (!module_on_i) begin
      dhigh_nxt = `CRC_RST_HALF;
      push_req = 1'b0;
    end
  end

  // A word is accepted only while there is room, or a word leaves this cycle.
  assign push_ok = push_req && ((fif.count < depth) || pop);
  assign fif.ce = ce_i;
  assign fif.clear = !module_on_i;
  assign fif.push = push_ok;
  assign fif.push_data = {dhigh_nxt, dlow_nxt} & width_mask;
  assign fif.pop = pop;

  // Two serial CRC steps over the buffer, in the selected order.
  always_comb begin
    crc_pkg::word_t c;
    crc_pkg::word_t b;
    logic din;
    logic fb;
    c = crc_r;
    b = buf_r;
    din = 1'b0;
    fb = 1'b0;
    nsteps = (bits_r >= `CRC_BITS_PER_CYCLE) ? `CRC_BITS_PER_CYCLE : bits_r;
    for (int k = 0; k < 2; k++) begin
      if (k < int'(nsteps)) begin
        din = lsb_first_select_i ? b[0] : b[data_width_field_i];
        b = lsb_first_select_i ? (b >> 1) : (b << 1);
        fb = c[poly_length_field_i] ^ din;
        c = (c << 1) & len_mask;
        if (fb) begin
          c = c ^ poly;
        end
      end
    end
    crc_step = c;
    buf_step = b;
  end

  // Engine sequencing, go bit, result writes and interrupt selection.
  always_comb begin
    state_nxt = state_r;
    buf_nxt = buf_r;
    bits_nxt = bits_r;
    crc_nxt = crc_r;
    go_nxt = go_r;
    irq_nxt = 1'b0;
    pop = 1'b0;
    hw_done = 1'b0;
    unique case (state_r)
      crc_pkg::ST_IDLE: begin
        if (go_r && (fif.count != `CRC_RST_CNT)) begin
          pop = 1'b1;
          buf_nxt = fif.pop_data;
          bits_nxt = {1'b0, data_width_field_i} + 6'h01;
          state_nxt = crc_pkg::ST_SHIFT;
        end
      end
      crc_pkg::ST_SHIFT: begin
        crc_nxt = crc_step;
        buf_nxt = buf_step;
        bits_nxt = bits_r - nsteps;
        if (bits_r <= `CRC_BITS_PER_CYCLE) begin
          state_nxt = crc_pkg::ST_IDLE;
          if (go_r && (fif.count == `CRC_RST_CNT) && !push_ok) begin
            hw_done = 1'b1;
            go_nxt = 1'b0;
          end
        end
      end
    endcase
    // Software result writes win over the engine in the same cycle.
    if (result_low_wr_i) begin
      crc_nxt[15:0] = result_wdata_i;
    end
    if (result_high_wr_i) begin
      crc_nxt[31:16] = result_wdata_i;
    end
    // A software set wins over any clear in the same cycle.
    if (shift_go_clr_i) begin
      go_nxt = 1'b0;
    end
    if (shift_go_set_i) begin
      go_nxt = 1'b1;
    end
    if (irq_condition_select_i) begin
      irq_nxt = hw_done;
    end else begin
      irq_nxt = pop && (fif.count == 5'h01) && !push_ok;
    end
    if (!module_on_i) begin
      state_nxt = crc_pkg::ST_IDLE;
      buf_nxt = `CRC_RST_WORD;
      bits_nxt = `CRC_RST_BITS;
      crc_nxt = `CRC_RST_WORD;
      irq_nxt = 1'b0;
    end
  end

  // Registers all engine and data state.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= crc_pkg::ST_IDLE;
      buf_r <= `CRC_RST_WORD;
      bits_r <= `CRC_RST_BITS;
      crc_r <= `CRC_RST_WORD;
      go_r <= 1'b0;
      irq_r <= 1'b0;
      dlow_r <= `CRC_RST_HALF;
      dhigh_r <= `CRC_RST_HALF;
    end else if (ce_i) begin
      state_r <= state_nxt;
      buf_r <= buf_nxt;
      bits_r <= bits_nxt;
      crc_r <= crc_nxt;
      go_r <= go_nxt;
      irq_r <= irq_nxt;
      dlow_r <= dlow_nxt;
      dhigh_r <= dhigh_nxt;
    end
  end

  // Status outputs.
  assign shift_go_o = go_r;
  assign result_pair_o = crc_r;
  assign irq_o = irq_r;
  assign valid_word_count_o = fif.count;
  assign fifo_full_flag_o = (fif.count >= depth);
  assign fifo_empty_flag_o = (fif.count == `CRC_RST_CNT);
endmodule

// ### pkg/crc_params.svh
// Constants for the programmable CRC generator: widths, depths and reset values.
`ifndef CRC_PARAMS_SVH
`define CRC_PARAMS_SVH

`define CRC_WORD_W 32
`define CRC_HALF_W 16
`define CRC_FIELD_W 5
`define CRC_PTR_W 4
`define CRC_CNT_W 5
`define CRC_BITS_W 6
`define CRC_FIFO_SLOTS 16
`define CRC_DEPTH_WIDE 5'h04
`define CRC_DEPTH_MID 5'h08
`define CRC_DEPTH_NARROW 5'h10
`define CRC_WIDE_MIN 5'h10
`define CRC_MID_MIN 5'h08
`define CRC_BITS_PER_CYCLE 6'h02
`define CRC_RST_WORD 32'h0000_0000
`define CRC_RST_HALF 16'h0000
`define CRC_RST_CNT 5'h00
`define CRC_RST_PTR 4'h0
`define CRC_RST_BITS 6'h00
`define CRC_TERMS_FLOOR 32'hffff_fffe

`endif

// ### pkg/crc_pkg.sv
// Types shared by the CRC generator modules.
`include "crc_params.svh"
package crc_pkg;
  typedef logic [`CRC_WORD_W-1:0] word_t;
  typedef logic [`CRC_HALF_W-1:0] half_t;
  typedef logic [`CRC_CNT_W-1:0] count_t;
  // Shift engine states, one-hot.
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_SHIFT = 2'b10
  } state_t;
endpackage

// ### pkg/crc_fifo_if.sv
// Interface between the CRC engine and its data FIFO.
`timescale 1ns/10ps
interface crc_fifo_if;
  logic ce;                 // Clock enable; state freezes while low.
  logic clear;              // Empties the FIFO and zeroes the count.
  logic push;               // Stores push_data this cycle.
  crc_pkg::word_t push_data; // Word to store.
  logic pop;                // Drops the oldest word this cycle.
  crc_pkg::word_t pop_data; // Oldest word, valid while count is above zero.
  crc_pkg::count_t count;   // Number of stored words.
  modport engine (output ce, output clear, output push, output push_data, output pop, input pop_data, input count);
  modport store (input ce, input clear, input push, input push_data, input pop, output pop_data, output count);
endinterface

// ### rtl/crc_fifo.sv
// Data FIFO of the CRC generator: a ring of sixteen words with a live count.
`timescale 1ns/10ps
`include "crc_params.svh"
module crc_fifo (
  input wire logic clk_i,   // Clock.
  input wire logic rst_n_i, // Asynchronous reset, active low.
  crc_fifo_if.store fif     // Engine side.
);
  crc_pkg::word_t mem_r [`CRC_FIFO_SLOTS]; // Word storage.
  logic [`CRC_PTR_W-1:0] wr_ptr_r, wr_ptr_nxt; // Next slot to fill.
  logic [`CRC_PTR_W-1:0] rd_ptr_r, rd_ptr_nxt; // Oldest slot.
  crc_pkg::count_t cnt_r, cnt_nxt; // Stored word count.

  assign fif.pop_data = mem_r[rd_ptr_r];
  assign fif.count = cnt_r;

  // Pointer and count update; the depth limit is enforced by the engine.
  always_comb begin
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    cnt_nxt = cnt_r;
    if (fif.clear) begin
      wr_ptr_nxt = `CRC_RST_PTR;
      rd_ptr_nxt = `CRC_RST_PTR;
      cnt_nxt = `CRC_RST_CNT;
    end else begin
      if (fif.push) begin
        wr_ptr_nxt = wr_ptr_r + 4'h1;
      end
      if (fif.pop) begin
        rd_ptr_nxt = rd_ptr_r + 4'h1;
      end
      cnt_nxt = cnt_r + {4'h0, fif.push} - {4'h0, fif.pop};
    end
  end

  // Registers the pointers and count.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_r <= `CRC_RST_PTR;
      rd_ptr_r <= `CRC_RST_PTR;
      cnt_r <= `CRC_RST_CNT;
    end else if (fif.ce) begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Storage array; written only on an accepted push.
  always_ff @(posedge clk_i) begin
    if (fif.ce && fif.push && !fif.clear) begin
      mem_r[wr_ptr_r] <= fif.push_data;
    end
  end
endmodule

// ### tb/crc_gen_properties.sv
// Concurrent checks on the ports of the CRC generator.
`timescale 1ns/10ps
module crc_gen_properties (
  input wire logic clk_i, // Clock.
  input wire logic rst_n_i, // Reset, active low.
  input wire logic ce_i, // Clock enable.
  input wire logic module_on_i, // Module enable.
  input wire logic irq_condition_select_i, // Interrupt select.
  input wire logic [4:0] data_width_field_i, // Width minus one.
  input wire logic [15:0] poly_terms_low_i, // Low terms in.
  input wire logic [15:0] poly_terms_low_rd_o, // Low terms read back.
  input wire logic shift_go_clr_i, // Software go clear.
  input wire logic shift_go_o, // Go bit.
  input wire logic [4:0] valid_word_count_o, // Word count.
  input wire logic fifo_full_flag_o, // Full flag.
  input wire logic fifo_empty_flag_o, // Empty flag.
  input wire logic irq_o // Interrupt pulse.
);
  logic [4:0] depth; // Depth that the present width allows.
  // Wide words leave room for fewer entries.
  assign depth = (data_width_field_i > 5'h0f) ? 5'h04 : (data_width_field_i > 5'h07) ? 5'h08 : 5'h10;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_full_at_depth: assert property (fifo_full_flag_o == (valid_word_count_o >= depth))
    else $error("full flag disagrees with depth");
  a_empty_at_zero: assert property (fifo_empty_flag_o == (valid_word_count_o == 5'h00))
    else $error("empty flag disagrees with count");
  a_low_term_zero: assert property (poly_terms_low_rd_o == {poly_terms_low_i[15:1], 1'b0})
    else $error("lowest term bit not read as zero");
  a_off_count_zero: assert property (ce_i && !module_on_i |=> valid_word_count_o == 5'h00)
    else $error("count not cleared while off");
  a_count_one_step: assert property (ce_i && module_on_i |=>
    (valid_word_count_o - $past(valid_word_count_o)) inside {5'h00, 5'h01, 5'h1f})
    else $error("count moved by more than one");
  a_no_pop_idle: assert property (ce_i && module_on_i && !shift_go_o |=>
    valid_word_count_o >= $past(valid_word_count_o))
    else $error("word taken without go");
  a_irq_last_word: assert property (!irq_condition_select_i && ce_i && module_on_i &&
    valid_word_count_o == 5'h01 ##1 valid_word_count_o == 5'h00 |-> ##[0:1] irq_o)
    else $error("no interrupt on last word");
  a_irq_go_done: assert property (irq_condition_select_i && ce_i && shift_go_o &&
    !shift_go_clr_i ##1 !shift_go_o |-> ##[0:1] irq_o)
    else $error("no interrupt on finish");
  a_irq_one_pulse: assert property (irq_o && ce_i |=> !irq_o)
    else $error("interrupt wider than one cycle");
endmodule
bind programmable_crc_generator crc_gen_properties chk_u (.clk_i, .rst_n_i, .ce_i, .module_on_i,
  .irq_condition_select_i, .data_width_field_i, .poly_terms_low_i, .poly_terms_low_rd_o, .shift_go_clr_i,
  .shift_go_o, .valid_word_count_o, .fifo_full_flag_o, .fifo_empty_flag_o, .irq_o);

// ### tb/programmable_crc_generator_bench.sv
// Self-checking bench of the programmable CRC generator.
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module programmable_crc_generator_bench;
  logic clk_i, rst_n_i, ce_i, module_on_i, lsb_first_select_i, irq_condition_select_i;
  logic [4:0] poly_length_field_i, data_width_field_i, valid_word_count_o;
  logic [15:0] poly_terms_low_i, poly_terms_high_i, poly_terms_low_rd_o, data_wdata_i, result_wdata_i;
  logic shift_go_set_i, shift_go_clr_i, shift_go_o, data_input_low_wr_i, data_input_high_wr_i;
  logic result_low_wr_i, result_high_wr_i, fifo_full_flag_o, fifo_empty_flag_o, irq_o;
  logic [1:0] data_be_i; // Byte enables.
  logic [31:0] result_pair_o, exp_crc; // Result and its expected value.
  logic [4:0] wf [3] = '{5'h10, 5'h08, 5'h07}; // Width fields at the depth boundaries.
  logic [4:0] dp [3] = '{5'h04, 5'h08, 5'h10}; // Matching depths.
  int error_cnt, n_compared, irq_seen;
  programmable_crc_generator dut_u (.clk_i, .rst_n_i, .ce_i, .module_on_i, .lsb_first_select_i,
    .irq_condition_select_i, .poly_length_field_i, .data_width_field_i, .poly_terms_low_i, .poly_terms_high_i,
    .poly_terms_low_rd_o, .shift_go_set_i, .shift_go_clr_i, .shift_go_o, .data_input_low_wr_i,
    .data_input_high_wr_i, .data_be_i, .data_wdata_i, .result_low_wr_i, .result_high_wr_i, .result_wdata_i,
    .result_pair_o, .valid_word_count_o, .fifo_full_flag_o, .fifo_empty_flag_o, .irq_o);
  // Clock of 10 ns.
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Counts interrupt pulses.
  always @(posedge clk_i) if (irq_o === 1'b1) irq_seen++;
  // One data write pulse to the low or high half.
  task automatic wr(input logic hi, input logic [1:0] be, input logic [15:0] d);
    @(negedge clk_i);
    data_input_low_wr_i = !hi;
    data_input_high_wr_i = hi;
    data_be_i = be;
    data_wdata_i = d;
    @(negedge clk_i);
    data_input_low_wr_i = 1'b0;
    data_input_high_wr_i = 1'b0;
  endtask
  // One result half write.
  task automatic wres(input logic hi, input logic [15:0] d);
    @(negedge clk_i);
    result_low_wr_i = !hi;
    result_high_wr_i = hi;
    result_wdata_i = d;
    @(negedge clk_i);
    result_low_wr_i = 1'b0;
    result_high_wr_i = 1'b0;
  endtask
  // Writes one word, low half first, as the present width needs.
  task automatic push(input logic [31:0] w);
    if (data_width_field_i > 5'h0f) begin
      wr(1'b0, 2'h3, w[15:0]);
      wr(1'b1, 2'h3, w[31:16]);
    end else wr(1'b0, (data_width_field_i > 5'h07) ? 2'h3 : 2'h1, w[15:0]);
  endtask
  // Reference shift register, unreflected, fed in the selected order.
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] w);
    logic [32:0] m;
    logic [31:0] p;
    logic fb;
    int n;
    m = (33'h1 << (poly_length_field_i + 6'h01)) - 33'h1;
    p = {poly_terms_high_i, poly_terms_low_i[15:1], 1'b1} & m[31:0];
    n = data_width_field_i + 1;
    for (int i = 0; i < n; i++) begin
      fb = c[poly_length_field_i] ^ w[lsb_first_select_i ? i : n - 1 - i];
      c = (c << 1) & m[31:0];
      if (fb) c = c ^ p;
    end
    return c;
  endfunction
  // Runs two words through the engine and checks the outcome.
  task automatic run_crc(input logic [31:0] w0, input logic [31:0] w1);
    wres(1'b0, 16'h0000);
    wres(1'b1, 16'h0000);
    exp_crc = crc_step(crc_step(32'h0, w0), w1);
    push(w0);
    push(w1);
    @(negedge clk_i);
    `CHK(valid_word_count_o, 5'h02)
    irq_seen = 0;
    shift_go_set_i = 1'b1;
    @(negedge clk_i);
    shift_go_set_i = 1'b0;
    for (int i = 0; i < 300 && shift_go_o !== 1'b0; i++) @(negedge clk_i);
    repeat (2) @(negedge clk_i);
    `CHK(shift_go_o, 1'b0)
    `CHK(result_pair_o, exp_crc)
    `CHK(irq_seen, 1)
    `CHK(fifo_empty_flag_o, 1'b1)
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic wrap_up();
    $display("Compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Cuts a hang short.
  initial begin
    #100us;
    error_cnt++;
    wrap_up();
  end
  // Main sequence.
  initial begin
    {rst_n_i, lsb_first_select_i, irq_condition_select_i, shift_go_set_i, shift_go_clr_i} = 5'h00;
    {data_input_low_wr_i, data_input_high_wr_i, result_low_wr_i, result_high_wr_i, data_be_i} = 6'h00;
    {poly_length_field_i, data_width_field_i, data_wdata_i, result_wdata_i} = 42'h0;
    {poly_terms_low_i, poly_terms_high_i} = 32'h0;
    ce_i = 1'b1;
    module_on_i = 1'b1;
    repeat (6) @(negedge clk_i);
    rst_n_i = 1'b1;
    `CHK(fifo_empty_flag_o, 1'b1)
    poly_terms_low_i = 16'hffff;
    @(negedge clk_i);
    `CHK(poly_terms_low_rd_o, 16'hfffe)
    // Fill each depth one word past full; the extra word is dropped.
    for (int k = 0; k < 3; k++) begin
      data_width_field_i = wf[k];
      for (int j = 0; j <= dp[k]; j++) push(32'hffff_ffff);
      repeat (3) @(negedge clk_i);
      `CHK(valid_word_count_o, dp[k])
      `CHK(fifo_full_flag_o, 1'b1)
      module_on_i = 1'b0;
      @(negedge clk_i);
      `CHK(valid_word_count_o, 5'h00)
      module_on_i = 1'b1;
    end
    // A word completed while the clock enable is low must not be counted.
    ce_i = 1'b0;
    push(32'h0000_0011);
    ce_i = 1'b1;
    @(negedge clk_i);
    `CHK(valid_word_count_o, 5'h00)
    {data_width_field_i, poly_length_field_i, poly_terms_high_i, poly_terms_low_i} = {10'h0af, 32'h0001_1020};
    run_crc(32'h0000_00e5, 32'h0000_003a);
    {data_width_field_i, poly_length_field_i, poly_terms_high_i, poly_terms_low_i} = {10'h3ff, 32'h04c1_1db6};
    {lsb_first_select_i, irq_condition_select_i} = 2'b11;
    run_crc(32'h1234_5678, 32'h8000_0001);
    {data_width_field_i, poly_length_field_i, poly_terms_high_i, poly_terms_low_i} = {10'h107, 32'h0000_0106};
    {lsb_first_select_i, irq_condition_select_i} = 2'b00;
    run_crc(32'h0000_01ab, 32'h0000_0155);
    // A software clear lets the current word finish and raises no interrupt.
    irq_condition_select_i = 1'b1;
    push(32'h0000_0001);
    irq_seen = 0;
    shift_go_set_i = 1'b1;
    @(negedge clk_i);
    {shift_go_set_i, shift_go_clr_i} = 2'b01;
    @(negedge clk_i);
    shift_go_clr_i = 1'b0;
    repeat (12) @(negedge clk_i);
    `CHK(shift_go_o, 1'b0)
    `CHK(irq_seen, 0)
    `CHK(valid_word_count_o, 5'h00)
    irq_condition_select_i = 1'b0;
    wres(1'b0, 16'h1234);
    wres(1'b1, 16'habcd);
    `CHK(result_pair_o, 32'habcd_1234)
    module_on_i = 1'b0;
    @(negedge clk_i);
    `CHK(result_pair_o, 32'h0000_0000)
    module_on_i = 1'b1;
    wrap_up();
  end
endmodule
